// >>> logic/vga_refresh_pipeline.sv
// Refresh address generator, fetch FIFO and pixel formatter with palette
//
// Decided for this implementation: the register offsets and the Wishbone slave port.
`timescale 1ns/1ns

// ----------------------------------------
// Fetch FIFO
// ----------------------------------------
module fetch_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 count;
  } fifo_state_type;

  fifo_state_type s;
  fifo_state_type n;
  logic           push;
  logic           pop;

  assign in_ready_o  = (s.count != (AW+1)'(DEPTH));
  assign out_valid_o = (s.count != '0);
  assign out_data_o  = s.mem[s.rd];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_ready_i && out_valid_o;

  always_comb begin
    n = s;
    if (push) begin
      n.mem[s.wr] = in_data_i;
      n.wr        = (s.wr == AW'(DEPTH - 1)) ? '0 : AW'(s.wr + 1'b1);
    end
    if (pop) begin
      n.rd = (s.rd == AW'(DEPTH - 1)) ? '0 : AW'(s.rd + 1'b1);
    end
    n.count = (AW+1)'(s.count + push - pop);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end
endmodule

module vga_refresh_pipeline
  import vga_refresh_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             fb_rd_o,
  output logic      [15:0] fb_addr_o,
  input  wire logic        fb_valid_i,
  input  wire logic [31:0] fb_data_i,
  output logic      [7:0]  colour_index_o,
  output logic             pixel_valid_o,
  output logic             char_clk_o
);

  typedef struct packed {
    logic [7:0]       ctrl;
    logic [15:0]      start;
    logic [7:0]       width;
    logic [15:0]      pitch;
    logic [4:0]       repeat_n;
    logic [9:0]       split;
    logic [9:0]       frame;
    logic [15:0]      font;
    logic [5:0]       colour;
    logic [15:0][5:0] pal;
    logic             wb_ack;
    logic [31:0]      wb_dat;
    logic [16:0]      acc;
    logic [3:0]       dot;
    fetch_type        fetch;
    logic [15:0]      row_addr;
    logic [7:0]       col;
    logic [4:0]       scan;
    logic [9:0]       line;
    logic [31:0]      word;
    logic             fb_rd;
    logic [15:0]      fb_addr;
    logic [31:0]      cur;
    logic             cur_ok;
    logic [7:0]       raw;
    logic [7:0]       colour_index;
    logic             pix_valid;
    logic             char_clk;
    logic [3:0]       span;
  } state_type;

  state_type   s;
  state_type   n;
  logic        fifo_in_ready;
  logic        fifo_in_valid;
  logic        fifo_out_valid;
  logic        fifo_out_ready;
  logic [31:0] fifo_out_data;
  logic        enable;
  logic        hit;
  logic        wr;
  logic [31:0] wval;
  logic [16:0] inc;
  logic [16:0] sum;
  logic        dot_en;
  logic [3:0]  last_dot;
  format_type  fmt;
  logic [1:0]  shift;
  logic [9:0]  next_line;
  logic [3:0]  masked;

  // ----------------------------------------
  // Register helpers
  // ----------------------------------------
  function automatic logic [31:0] reg_read(input state_type st, input logic [7:0] adr);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (adr[7:6] == PAL_PAGE) begin
      v = {26'h0, st.pal[adr[5:2]]};
    end else begin
      case (adr)
        OFS_CTRL:   v = {24'h0, st.ctrl};
        OFS_START:  v = {16'h0, st.start};
        OFS_WIDTH:  v = {24'h0, st.width};
        OFS_PITCH:  v = {16'h0, st.pitch};
        OFS_REPEAT: v = {27'h0, st.repeat_n};
        OFS_SPLIT:  v = {22'h0, st.split};
        OFS_FRAME:  v = {22'h0, st.frame};
        OFS_FONT:   v = {16'h0, st.font};
        OFS_COLOUR: v = {26'h0, st.colour};
        OFS_STATUS: v = {11'h0, st.scan, 6'h0, st.line};
        default:    v = 32'h0000_0000;
      endcase
    end
    return v;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] sel);
    logic [31:0] v;
    v = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        v[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return v;
  endfunction

  // Raw pixel of a fetched word at dot position idx
  function automatic logic [7:0] pick(input format_type f, input logic [31:0] w, input logic [3:0] idx);
    int          i;
    logic [7:0]  v;
    i = (idx > 4'h7) ? 7 : int'(idx);
    v = 8'h00;
    unique case (f)
      FMT_TEXT: begin
        if (idx > 4'h7) begin
          v = {4'h0, w[15:12]};
        end else begin
          v = w[7 - i] ? {4'h0, w[11:8]} : {4'h0, w[15:12]};
        end
      end
      FMT_ODD_EVEN: begin
        if (i < 4) begin
          v = {4'h0, w[16 + 7 - 2*i -: 2], w[7 - 2*i -: 2]};
        end else begin
          v = {4'h0, w[24 + 7 - 2*(i-4) -: 2], w[8 + 7 - 2*(i-4) -: 2]};
        end
      end
      FMT_PLANAR: v = {4'h0, w[24 + 7 - i], w[16 + 7 - i], w[8 + 7 - i], w[7 - i]};
      FMT_EIGHT:  v = w[8*(i >> 1) +: 8];
    endcase
    return v;
  endfunction

  fetch_fifo #(
    .WIDTH (32),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (fifo_in_valid),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (s.word),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_out_ready),
    .out_data_o  (fifo_out_data)
  );

  assign fifo_in_valid  = (s.fetch == F_PUSH);
  // Next word is taken at the last dot so the first dot of a character has it whenever the FIFO holds a word; otherwise it shows raw 0
  assign fifo_out_ready = !s.cur_ok || n.char_clk;
  assign enable         = s.ctrl[CTRL_ENABLE_BIT];
  assign fmt            = format_type'(s.ctrl[CTRL_FMT_LSB +: 2]);
  assign shift          = s.ctrl[CTRL_SHIFT_LSB +: 2];
  assign hit            = wb_cyc_i && wb_stb_i && !s.wb_ack;
  assign wr             = hit && wb_we_i;
  assign masked         = s.raw[3:0] & s.colour[COLOUR_MASK_LSB +: 4];

  always_comb begin
    n           = s;
    n.fb_rd     = 1'b0;
    n.pix_valid = 1'b0;
    n.char_clk  = 1'b0;
    next_line   = 10'(s.line + 1'b1);

    // ----------------------------------------
    // Wishbone slave
    // ----------------------------------------
    n.wb_ack = hit;
    wval     = merge(reg_read(s, wb_adr_i), wb_dat_i, wb_sel_i);
    if (hit && !wb_we_i) begin
      n.wb_dat = reg_read(s, wb_adr_i);
    end
    if (wr) begin
      if (wb_adr_i[7:6] == PAL_PAGE) begin
        n.pal[wb_adr_i[5:2]] = wval[5:0];
      end else begin
        case (wb_adr_i)
          OFS_CTRL:   n.ctrl     = wval[7:0];
          OFS_START:  n.start    = wval[15:0];
          OFS_WIDTH:  n.width    = wval[7:0];
          OFS_PITCH:  n.pitch    = wval[15:0];
          OFS_REPEAT: n.repeat_n = wval[4:0];
          OFS_SPLIT:  n.split    = wval[9:0];
          OFS_FRAME:  n.frame    = wval[9:0];
          OFS_FONT:   n.font     = wval[15:0];
          OFS_COLOUR: n.colour   = wval[5:0];
          default:    n.wb_dat   = s.wb_dat;
        endcase
      end
    end

    // ----------------------------------------
    // Refresh fetch engine
    // ----------------------------------------
    unique case (s.fetch)
      F_IDLE: begin
        n.row_addr = s.start;
        n.col      = 8'h00;
        n.scan     = 5'h00;
        n.line     = 10'h000;
        if (enable) begin
          n.fetch = F_MAIN;
        end
      end
      F_MAIN: begin
        n.fb_addr = 16'((s.row_addr + 16'(s.col)) << shift);
        n.fb_rd   = 1'b1;
        n.fetch   = F_MAIN_WAIT;
      end
      F_MAIN_WAIT: begin
        if (fb_valid_i) begin
          n.word  = fb_data_i;
          n.fetch = (fmt == FMT_TEXT) ? F_FONT : F_PUSH;
        end
      end
      F_FONT: begin
        n.fb_addr = 16'(s.font + {3'h0, s.word[7:0], s.scan});
        n.fb_rd   = 1'b1;
        n.fetch   = F_FONT_WAIT;
      end
      F_FONT_WAIT: begin
        if (fb_valid_i) begin
          n.word  = {16'h0000, s.word[15:8], fb_data_i[23:16]};
          n.fetch = F_PUSH;
        end
      end
      F_PUSH: begin
        if (fifo_in_ready) begin
          n.fetch = enable ? F_MAIN : F_IDLE;
          if (s.col != 8'(s.width - 1'b1)) begin
            n.col = 8'(s.col + 1'b1);
          end else begin
            n.col = 8'h00;
            if (s.line == s.frame) begin
              n.line     = 10'h000;
              n.row_addr = s.start;
              n.scan     = 5'h00;
            end else if (next_line == s.split) begin
              n.line     = next_line;
              n.row_addr = 16'h0000;
              n.scan     = 5'h00;
            end else if (s.scan == s.repeat_n) begin
              n.line     = next_line;
              n.row_addr = 16'(s.row_addr + s.pitch);
              n.scan     = 5'h00;
            end else begin
              n.line = next_line;
              n.scan = 5'(s.scan + 1'b1);
            end
          end
        end
      end
    endcase

    // ----------------------------------------
    // Dot and character clocks
    // ----------------------------------------
    // master select and halving
    inc      = s.ctrl[CTRL_CLKSEL_BIT] ? MASTER_HIGH_KHZ : MASTER_LOW_KHZ;
    inc      = s.ctrl[CTRL_DIV2_BIT] ? 17'(inc >> 1) : inc;
    sum      = 17'(s.acc + inc);
    dot_en   = 1'b0;
    last_dot = s.ctrl[CTRL_DOT9_BIT] ? LAST_DOT_WIDE : LAST_DOT_NARROW;
    if (!enable) begin
      n.acc = 17'h00000;
      n.dot = 4'h0;
    end else if (sum >= CLK_KHZ) begin
      dot_en = 1'b1;
      n.acc  = 17'(sum - CLK_KHZ);
      if (n.acc >= CLK_KHZ) begin
        n.acc = 17'(CLK_KHZ - 1'b1);
      end
    end else begin
      n.acc = sum;
    end

    // ----------------------------------------
    // Pixel formatter and palette
    // ----------------------------------------
    if (dot_en) begin
      n.pix_valid = 1'b1;
      n.raw       = s.cur_ok ? pick(fmt, s.cur, s.dot) : 8'h00;
      n.span      = 4'(s.span + 1'b1);
      if (s.dot >= last_dot) begin
        n.dot      = 4'h0;
        n.char_clk = 1'b1;
        n.cur_ok   = 1'b0;
        n.span     = 4'h0;
      end else begin
        n.dot = 4'(s.dot + 1'b1);
      end
    end
    if (s.pix_valid) begin
      if (fmt == FMT_EIGHT) begin
        n.colour_index = s.raw;
      end else begin
        n.colour_index = {s.colour[COLOUR_UPPER_LSB +: 2], s.pal[masked]};
      end
    end
    if ((!s.cur_ok || n.char_clk) && fifo_out_valid) begin
      n.cur    = fifo_out_data;
      n.cur_ok = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s          <= '0;
      s.ctrl     <= RST_CTRL;
      s.start    <= RST_START;
      s.width    <= RST_WIDTH;
      s.pitch    <= RST_PITCH;
      s.repeat_n <= RST_REPEAT;
      s.split    <= RST_SPLIT;
      s.frame    <= RST_FRAME;
      s.font     <= RST_FONT;
      s.colour   <= RST_COLOUR;
      s.fetch    <= F_IDLE;
    end else begin
      s <= n;
    end
  end

  assign wb_dat_o       = s.wb_dat;
  assign wb_ack_o       = s.wb_ack;
  assign fb_rd_o        = s.fb_rd;
  assign fb_addr_o      = s.fb_addr;
  assign colour_index_o = s.colour_index;
  assign pixel_valid_o  = s.pix_valid;
  assign char_clk_o     = s.char_clk;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_dot_rate;
    @(posedge clk_i) disable iff (rst_i)
      s.ctrl[CTRL_DIV2_BIT] && $past(s.ctrl[CTRL_DIV2_BIT], 3) && s.pix_valid && $past(s.pix_valid) &&
        $past(s.pix_valid, 2) |=> !s.pix_valid;
  endproperty
  a_dot_rate: assert property (p_dot_rate) else $error("dot pulses too close with halving");

  property p_char_span;
    @(posedge clk_i) disable iff (rst_i)
      s.char_clk && $past(s.char_clk) == 1'b0 && $stable(s.ctrl) |->
        $past(s.dot) == (s.ctrl[CTRL_DOT9_BIT] ? LAST_DOT_WIDE : LAST_DOT_NARROW);
  endproperty
  a_char_span: assert property (p_char_span) else $error("character clock not at last dot");

  property p_col_step;
    @(posedge clk_i) disable iff (rst_i)
      s.fetch == F_PUSH && fifo_in_ready && s.col != 8'(s.width - 1'b1) |=> s.col == 8'($past(s.col) + 1'b1);
  endproperty
  a_col_step: assert property (p_col_step) else $error("column did not step by one");

  property p_addr_shift;
    @(posedge clk_i) disable iff (rst_i)
      s.fb_rd && s.fetch == F_MAIN_WAIT |-> s.fb_addr == 16'((s.row_addr + 16'(s.col)) << shift);
  endproperty
  a_addr_shift: assert property (p_addr_shift) else $error("fetch address shift wrong");

  property p_font_addr;
    @(posedge clk_i) disable iff (rst_i)
      s.fb_rd && s.fetch == F_FONT_WAIT |-> s.fb_addr == 16'(s.font + {3'h0, s.word[7:0], s.scan});
  endproperty
  a_font_addr: assert property (p_font_addr) else $error("font address wrong");

  property p_split;
    @(posedge clk_i) disable iff (rst_i)
      s.fetch == F_PUSH && fifo_in_ready && s.col == 8'(s.width - 1'b1) && s.line != s.frame &&
        next_line == s.split |=> s.row_addr == 16'h0000 && s.scan == 5'h00;
  endproperty
  a_split: assert property (p_split) else $error("split line did not reset address");

  property p_frame_start;
    @(posedge clk_i) disable iff (rst_i)
      s.fetch == F_PUSH && fifo_in_ready && s.col == 8'(s.width - 1'b1) && s.line == s.frame
        |=> s.row_addr == $past(s.start) && s.line == 10'h000;
  endproperty
  a_frame_start: assert property (p_frame_start) else $error("frame did not restart at start");

  property p_scan_repeat;
    @(posedge clk_i) disable iff (rst_i)
      s.fetch == F_PUSH && fifo_in_ready && s.col == 8'(s.width - 1'b1) && s.line != s.frame &&
        next_line != s.split && s.scan != s.repeat_n |=> $stable(s.row_addr) && s.scan == 5'($past(s.scan) + 1'b1);
  endproperty
  a_scan_repeat: assert property (p_scan_repeat) else $error("repeated line moved address");

  property p_bypass;
    @(posedge clk_i) disable iff (rst_i)
      s.pix_valid && fmt == FMT_EIGHT && $stable(s.ctrl) |=> s.colour_index == $past(s.raw);
  endproperty
  a_bypass: assert property (p_bypass) else $error("eight-bit pixel altered");

  property p_palette;
    @(posedge clk_i) disable iff (rst_i)
      s.pix_valid && fmt != FMT_EIGHT && $stable(s.ctrl) && !wr |=>
        s.colour_index == {$past(s.colour[COLOUR_UPPER_LSB +: 2]), $past(s.pal[masked])};
  endproperty
  a_palette: assert property (p_palette) else $error("palette index wrong");
endmodule

// >>> logic/vga_refresh_pkg.sv
// Shared constants and types for the display refresh pipeline
package vga_refresh_pkg;

  // ----------------------------------------
  // Clock rates
  // ----------------------------------------
  localparam int          CLK_MHZ         = 20;
  localparam int          MASTER_LOW_MHZ  = 25;
  localparam int          MASTER_HIGH_MHZ = 28;
  localparam logic [16:0] CLK_KHZ         = 17'(CLK_MHZ * 1000);
  localparam logic [16:0] MASTER_LOW_KHZ  = 17'(MASTER_LOW_MHZ * 1000);
  localparam logic [16:0] MASTER_HIGH_KHZ = 17'(MASTER_HIGH_MHZ * 1000);

  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_START  = 8'h04;
  localparam logic [7:0] OFS_WIDTH  = 8'h08;
  localparam logic [7:0] OFS_PITCH  = 8'h0C;
  localparam logic [7:0] OFS_REPEAT = 8'h10;
  localparam logic [7:0] OFS_SPLIT  = 8'h14;
  localparam logic [7:0] OFS_FRAME  = 8'h18;
  localparam logic [7:0] OFS_FONT   = 8'h1C;
  localparam logic [7:0] OFS_COLOUR = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  localparam logic [1:0] PAL_PAGE   = 2'h1;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CTRL_ENABLE_BIT  = 0;
  localparam int CTRL_CLKSEL_BIT  = 1;
  localparam int CTRL_DIV2_BIT    = 2;
  localparam int CTRL_DOT9_BIT    = 3;
  localparam int CTRL_FMT_LSB     = 4;
  localparam int CTRL_SHIFT_LSB   = 6;
  localparam int COLOUR_MASK_LSB  = 0;
  localparam int COLOUR_UPPER_LSB = 4;
  localparam int STATUS_SCAN_LSB  = 16;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0]  RST_CTRL   = 8'h00;
  localparam logic [15:0] RST_START  = 16'h0000;
  localparam logic [7:0]  RST_WIDTH  = 8'h50;
  localparam logic [15:0] RST_PITCH  = 16'h0050;
  localparam logic [4:0]  RST_REPEAT = 5'h00;
  localparam logic [9:0]  RST_SPLIT  = 10'h3FF;
  localparam logic [9:0]  RST_FRAME  = 10'h1DF;
  localparam logic [15:0] RST_FONT   = 16'h8000;
  localparam logic [5:0]  RST_COLOUR = 6'h0F;

  // ----------------------------------------
  // Last dot number per character (8 and 9 dots)
  // ----------------------------------------
  localparam logic [3:0] LAST_DOT_NARROW = 4'h7;
  localparam logic [3:0] LAST_DOT_WIDE   = 4'h8;

  typedef enum logic [1:0] {FMT_TEXT, FMT_ODD_EVEN, FMT_PLANAR, FMT_EIGHT} format_type;
  typedef enum logic [2:0] {F_IDLE, F_MAIN, F_MAIN_WAIT, F_FONT, F_FONT_WAIT, F_PUSH} fetch_type;

endpackage

// >>> sim/fb_model.sv
// Frame buffer model answering refresh reads, alternately prompt and slow
`timescale 1ns/1ns
module fb_model (
  input  wire logic        clk_i,
  input  wire logic        fb_rd_i,
  input  wire logic [15:0] fb_addr_i,
  output logic             fb_valid_o,
  output logic      [31:0] fb_data_o
);
  logic [31:0] log_q[$];
  logic [15:0] addr_q[$];
  logic [2:0]  wait_cnt = 3'h0;
  logic        busy     = 1'b0;
  logic        slow     = 1'b0;

  function automatic logic [31:0] word_at(input logic [15:0] a);
    return {~a[7:0], a[7:0] ^ 8'h5A, a[7:0] + 8'h11, a[7:0] ^ a[15:8]};
  endfunction

  initial begin
    fb_valid_o = 1'b0;
    fb_data_o  = 32'h0;
  end

  // One read open at a time; data lines churn when not valid
  always @(posedge clk_i) begin
    fb_valid_o <= 1'b0;
    fb_data_o  <= ~fb_data_o;
    if (fb_rd_i) begin
      addr_q.push_back(fb_addr_i);
      busy     <= 1'b1;
      wait_cnt <= slow ? 3'h3 : 3'h0;
      slow     <= ~slow;
    end else if (busy && wait_cnt != 3'h0) begin
      wait_cnt <= wait_cnt - 3'h1;
    end else if (busy) begin
      busy       <= 1'b0;
      fb_valid_o <= 1'b1;
      fb_data_o  <= word_at(addr_q[$]);
      log_q.push_back(word_at(addr_q[$]));
    end
  end
endmodule

// >>> sim/tb_vga_refresh_pipeline.sv
// Register, address and pixel stream tests of the refresh pipeline
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module tb_vga_refresh_pipeline;
  import vga_refresh_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic        ack, fb_rd, fb_valid, pv, cc, pv_d = 1'b0;
  logic [15:0] fb_addr;
  logic [31:0] fb_data;
  logic [7:0]  cidx;
  logic [7:0]  pix_q[$];
  int          miscompares = 0, n_compared = 0, dots, chars, d0, c0;

  vga_refresh_pipeline dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .fb_rd_o(fb_rd),
    .fb_addr_o(fb_addr), .fb_valid_i(fb_valid), .fb_data_i(fb_data), .colour_index_o(cidx),
    .pixel_valid_o(pv), .char_clk_o(cc));
  fb_model model (.clk_i(clk), .fb_rd_i(fb_rd), .fb_addr_i(fb_addr), .fb_valid_o(fb_valid), .fb_data_o(fb_data));

  initial begin
    forever #25 clk = ~clk;
  end

  // Index of a dot appears the cycle after its pulse
  always @(posedge clk) begin
    pv_d <= pv & ~rst;
    if (pv_d) pix_q.push_back(cidx);
    dots  <= dots + int'(pv);
    chars <= chars + int'(cc);
  end

  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      miscompares++;
      results();
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask

  task automatic restart;
    rst <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    pix_q.delete();
    model.log_q.delete();
    model.addr_q.delete();
  endtask

  function automatic logic [7:0] ctrl(logic cs, logic d9, logic [1:0] f, logic [1:0] sh);
    return {sh, f, d9, 1'b1, cs, 1'b1};
  endfunction

  function automatic logic [7:0] exp_pix(logic [1:0] f, logic [31:0] w, int i);
    logic [3:0] r;
    if (f == 2'h3) return w[8*(i/2) +: 8];
    if (f == 2'h2) r = {w[31-i], w[23-i], w[15-i], w[7-i]};
    else if (i < 4) r = {w[23-2*i -: 2], w[7-2*i -: 2]};
    else r = {w[31-2*(i-4) -: 2], w[15-2*(i-4) -: 2]};
    r = r & 4'hB;
    return {2'h2, 6'(r * 3 + 1)};
  endfunction

  // Finds the word behind one displayed character, then follows the stream
  task automatic stream(input logic [1:0] f, input logic [1:0] sh);
    int k;
    logic hit;
    restart();
    for (int i = 0; i < 16; i++) wb(1'b1, 8'h40 + 8'(4 * i), 32'(i * 3 + 1), 4'hF);
    wb(1'b1, OFS_COLOUR, 32'h2B, 4'hF);
    wb(1'b1, OFS_CTRL, 32'(ctrl(1'b0, 1'b0, f, sh)), 4'hF);
    repeat (600) @(posedge clk);
    k = -1;
    for (int j = 0; j < model.log_q.size() && k < 0; j++) begin
      hit = 1'b1;
      for (int i = 0; i < 8; i++) if (pix_q[32+i] !== exp_pix(f, model.log_q[j], i)) hit = 1'b0;
      if (hit) k = j;
    end
    `CHK("sync", 1'b1, k >= 0)
    for (int c = 1; c < 24 && k >= 0; c++)
      for (int i = 0; i < 8; i++) `CHK("pixel", exp_pix(f, model.log_q[k+c], i), pix_q[32+8*c+i])
    $display("stream test format %0d done", f);
  endtask

  initial begin
    restart();
    // Register defaults, byte lanes and an unmapped place
    wb(1'b0, OFS_WIDTH, 32'h0, 4'hF);
    `CHK("width", 32'h50, q)
    wb(1'b0, OFS_SPLIT, 32'h0, 4'hF);
    `CHK("split", 32'h3FF, q)
    wb(1'b0, OFS_FRAME, 32'h0, 4'hF);
    `CHK("frame", 32'h1DF, q)
    wb(1'b0, OFS_COLOUR, 32'h0, 4'hF);
    `CHK("colour", 32'h0F, q)
    wb(1'b1, OFS_START, 32'h1234ABCD, 4'h1);
    wb(1'b0, OFS_START, 32'h0, 4'hF);
    `CHK("start", 32'hCD, q)
    wb(1'b1, 8'h3C, 32'hFFFFFFFF, 4'hF);
    wb(1'b0, 8'h3C, 32'h0, 4'hF);
    `CHK("unmapped", 32'h0, q)
    $display("register test done");
    // Start, width, pitch, repeat, split and shift
    wb(1'b1, OFS_START, 32'h100, 4'hF);
    wb(1'b1, OFS_WIDTH, 32'h4, 4'hF);
    wb(1'b1, OFS_PITCH, 32'h10, 4'hF);
    wb(1'b1, OFS_REPEAT, 32'h1, 4'hF);
    wb(1'b1, OFS_SPLIT, 32'h3, 4'hF);
    wb(1'b1, OFS_FRAME, 32'h7, 4'hF);
    wb(1'b1, OFS_CTRL, 32'(ctrl(1'b0, 1'b0, 2'h2, 2'h1)), 4'hF);
    repeat (400) @(posedge clk);
    for (int i = 0; i < 16; i++) begin
      q = (i < 8) ? 32'h100 : ((i < 12) ? 32'h110 : 32'h0);
      `CHK("fetch addr", 16'((16'(q) + 16'(i % 4)) << 1), model.addr_q[i])
    end
    $display("address test done");
    // Text: character word, then glyph row of that code
    restart();
    wb(1'b1, OFS_START, 32'h20, 4'hF);
    wb(1'b1, OFS_CTRL, 32'(ctrl(1'b0, 1'b0, 2'h0, 2'h0)), 4'hF);
    repeat (100) @(posedge clk);
    `CHK("text main", 16'h20, model.addr_q[0])
    `CHK("text font", 16'h8400, model.addr_q[1])
    `CHK("text next", 16'h21, model.addr_q[2])
    $display("text test done");
    stream(2'h1, 2'h0);
    stream(2'h2, 2'h0);
    stream(2'h3, 2'h2);
    // Dot and character rates
    for (int m = 0; m < 2; m++) begin
      restart();
      wb(1'b1, OFS_CTRL, 32'(ctrl(1'(m), 1'(m), 2'h3, 2'h0)), 4'hF);
      d0 = dots;
      c0 = chars;
      repeat (800) @(posedge clk);
      d0 = dots - d0;
      c0 = chars - c0;
      `CHK("dot rate", 1'b1, d0 >= (m ? 559 : 499) && d0 <= (m ? 561 : 501))
      `CHK("char rate", 1'b1, c0 * (8 + m) <= d0 && c0 * (8 + m) > d0 - 9 - m)
      $display("rate test %0d done", m);
    end
    results();
  end
endmodule
